// File: ocp_checker.sv
// Port-level checker for the compare channel.
// Assumes it is bound onto ocp_output_compare and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ocp_checker (
  input wire logic        ref_clk,            // Clock
  input wire logic        sys_rst,            // Reset, high
  input wire logic        psel,               // Select
  input wire logic        penable,            // Enable
  input wire logic        pwrite,             // Direction
  input wire logic [7:0]  paddr,              // Address
  input wire logic [31:0] pwdata,             // Write data
  input wire logic [31:0] prdata,             // Read data
  input wire logic        pready,             // Ready
  input wire logic        pslverr,            // Error
  input wire logic        fault_input_pin,    // Fault
  input wire logic        compare_output_pin, // Pin
  input wire logic        compare_irq         // Irq
);
  logic [2:0] mode_sh;                                   // Mode as last written
  logic       en_sh;                                     // Irq enable as written
  logic       flt_sh;                                    // Fault caught in 111
  wire        setup  = psel && !penable;                 // Setup cycle
  wire        acc    = psel && penable && pready && pwrite; // Write lands
  wire        ctl_wr = acc && paddr == 8'h00;            // Control write
  // Shadows of software state; a fault only clears on a control write
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_sh <= 3'h0;
      en_sh   <= 1'b0;
      flt_sh  <= 1'b0;
    end else begin
      if (ctl_wr) mode_sh <= pwdata[2:0];
      if (acc && paddr == 8'h10) en_sh <= pwdata[0];
      if (ctl_wr) flt_sh <= 1'b0;
      else if (mode_sh == 3'h7 && fault_input_pin) flt_sh <= 1'b1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_ready_setup: assert property (setup |=> pready && penable)
    else $error("ready missing after setup");
  a_ready_access: assert property (pready |-> psel && penable && $past(setup))
    else $error("ready outside access");
  a_err_decode: assert property (setup |=> pslverr == (paddr > 8'h28 || paddr[1:0] != 2'h0))
    else $error("error flag wrong for address");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_init_low: assert property (
    ctl_wr && pwdata[2:0] inside {3'h0, 3'h1, 3'h3, 3'h4, 3'h5} |=> !compare_output_pin)
    else $error("pin not low after mode write");
  a_init_high: assert property (
    ctl_wr && pwdata[2:0] == 3'h2 |=> compare_output_pin)
    else $error("pin not high after mode write");
  a_fault_hold: assert property (flt_sh |-> !compare_output_pin)
    else $error("pin high after fault");
  a_irq_gate: assert property (!en_sh && !$past(en_sh) |-> !compare_irq)
    else $error("irq while disabled");
endmodule
bind ocp_output_compare ocp_checker u_chk (.ref_clk, .sys_rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .fault_input_pin, .compare_output_pin,
  .compare_irq);
`default_nettype wire

// File: ocp_load.sv
// Model of the load on the compare pin: counts rising edges and high cycles.
// Assumes the bench restarts it before each observation window.
`timescale 1ns/10ps
`default_nettype none
module ocp_load (
  input  wire logic       ref_clk, // Clock
  input  wire logic       sys_rst, // Reset, high
  input  wire logic       clr,     // Restart counts
  input  wire logic       pin,     // Compare output
  output logic      [7:0] rises,   // Rising edges seen
  output logic      [7:0] highs    // High cycles seen
);
  logic prev; // Pin one cycle back
  // Pure observer: a resistive load never drives back
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rises <= 8'h00;
      highs <= 8'h00;
    end else if (clr) begin
      rises <= 8'h00;
      highs <= 8'h00;
    end else begin
      rises <= rises + {7'h00, pin & ~prev};
      highs <= highs + {7'h00, pin};
    end
  end
  // Edge history kept apart so a restart still sees the true level
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) prev <= 1'b0;
    else prev <= pin;
  end
endmodule
`default_nettype wire

// File: ocp_map.vh
// Register map and field layout of the output compare channel.
// Assumes 32-bit APB access with one register per aligned word.
`ifndef OCP_MAP_VH
`define OCP_MAP_VH
// Byte offsets
`define OCP_CONTROL_OFF    8'h00
`define OCP_PRIMARY_OFF    8'h04
`define OCP_SECONDARY_OFF  8'h08
`define OCP_IRQ_FLAG_OFF   8'h0C
`define OCP_IRQ_EN_OFF     8'h10
`define OCP_TB0_CTRL_OFF   8'h14
`define OCP_TB0_PERIOD_OFF 8'h18
`define OCP_TB0_COUNT_OFF  8'h1C
`define OCP_TB1_CTRL_OFF   8'h20
`define OCP_TB1_PERIOD_OFF 8'h24
`define OCP_TB1_COUNT_OFF  8'h28
// Field positions
`define OCP_MODE_LSB       0
`define OCP_MODE_MSB       2
`define OCP_TSEL_BIT       3
`define OCP_FAULT_BIT      4
`define OCP_RUN_BIT        15
// Mode codes
`define OCP_MODE_OFF       3'h0
`define OCP_MODE_SET_HIGH  3'h1
`define OCP_MODE_SET_LOW   3'h2
`define OCP_MODE_TOGGLE    3'h3
`define OCP_MODE_SINGLE    3'h4
`define OCP_MODE_CONT      3'h5
`define OCP_MODE_PWM       3'h6
`define OCP_MODE_PWM_FLT   3'h7
// Reset values
`define OCP_RST16          16'h0000
`define OCP_PERIOD_RST     16'hFFFF
`endif

// File: ocp_output_compare.v
// Output compare channel with single pulse, continuous pulse and PWM.
// Assumes an APB master on ref_clk and a synchronous fault input.
// Operation
// RL1 - Single-pulse code drives output low, arms
// RL2 - Pulse modes: primary match drives high
// RL3 - Single pulse: secondary match low, done
// RL4 - Single pulse: secondary match sets flag
// RL5 - Rewriting single-pulse code rearms pulse
// RL6 - Continuous: low, then pulse each period
// RL7 - Count wraps to zero at period
// RL8 - Continuous: every secondary match sets flag
// RL9 - Control bit 3 selects time base
// RL10 - Time base counts only while run set
// RL11 - Software keeps period at least secondary
// RL12 - PWM: primary register read-only
// RL13 - PWM: secondary copied at period match
// RL14 - Primary value sets first PWM duty
// RL15 - Period N gives N+1 counts
// RL16 - Duty zero holds output low
// RL17 - Duty above period holds output high
// RL18 - Duty equal period: low one count
// RL19 - Software enables interrupt for fault use
// RL20 - Code 111 PWM with fault, 110 without
// RL21 - Fault status set by fault, hardware-cleared
// RL22 - Codes 000 off, 001, 010, 011
// RL23 - Select one picks second time base
// RL24 - Fault forces output low until rewrite
// RL25 - All values 16 bits, exact compare
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ocp_map.vh"
module ocp_output_compare (
  input  wire        ref_clk,            // Core clock, 10 MHz
  input  wire        sys_rst,            // Async reset, high
  input  wire        psel,               // APB select
  input  wire        penable,            // APB enable
  input  wire        pwrite,             // APB direction
  input  wire [7:0]  paddr,              // APB byte address
  input  wire [31:0] pwdata,             // APB write data
  output reg  [31:0] prdata,             // APB read data
  output reg         pready,             // APB ready
  output reg         pslverr,            // APB error, unmapped
  input  wire        fault_input_pin,    // Fault, active high
  output reg         compare_output_pin, // Compare output
  output reg         compare_irq         // Interrupt request
);
  // Software-visible state, then internal pulse and output state
  reg [2:0]  compare_mode_select;     // Mode field
  reg        timebase_select;         // Time base choice
  reg        fault_status;            // Fault latched
  reg [15:0] primary_compare_value;   // Primary / duty
  reg [15:0] secondary_compare_value; // Secondary / next duty
  reg        compare_irq_flag;        // Sticky flag
  reg        compare_irq_enable;      // Flag gate
  reg        run0;                    // First time base run
  reg        run1;                    // Second time base run
  reg [15:0] period0;                 // First period
  reg [15:0] period1;                 // Second period
  reg        armed;                   // Single pulse pending
  reg        next_out;                // Output next value
  reg        next_flag_set;           // Event this cycle

  wire [15:0] count0;   // First count
  wire [15:0] count1;   // Second count
  wire        hit0;     // First period match
  wire        hit1;     // Second period match
  wire [15:0] timer_count;       // Selected count
  wire        timebase_run;       // Selected run
  wire        period_hit;         // Selected period match

  // APB phase decode; pready rises in the access phase only
  wire setup   = psel && !penable;
  wire wr_en   = psel && penable && pwrite && pready;
  wire mapped  = addr_ok(paddr);
  wire mode_wr = wr_en && (paddr == `OCP_CONTROL_OFF);

  // Address decode used by the error path only; writes decode paddr directly
  function addr_ok;
    input [7:0] a;
    begin
      case (a)
        `OCP_CONTROL_OFF, `OCP_PRIMARY_OFF, `OCP_SECONDARY_OFF,
        `OCP_IRQ_FLAG_OFF, `OCP_IRQ_EN_OFF, `OCP_TB0_CTRL_OFF,
        `OCP_TB0_PERIOD_OFF, `OCP_TB0_COUNT_OFF, `OCP_TB1_CTRL_OFF,
        `OCP_TB1_PERIOD_OFF, `OCP_TB1_COUNT_OFF: addr_ok = 1'b1;
        default: addr_ok = 1'b0;
      endcase
    end
  endfunction

  // PWM codes share the read-only duty behaviour
  function is_pwm;
    input [2:0] m;
    begin
      is_pwm = (m == `OCP_MODE_PWM) || (m == `OCP_MODE_PWM_FLT); // see RL20
    end
  endfunction

  // Two time bases, identical hardware
  ocp_timebase u_tb0 (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .run        (run0),
    .period     (period0),
    .load       (wr_en && (paddr == `OCP_TB0_COUNT_OFF)),
    .load_value (pwdata[15:0]),
    .count      (count0),
    .period_hit (hit0)
  );
  ocp_timebase u_tb1 (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .run        (run1),
    .period     (period1),
    .load       (wr_en && (paddr == `OCP_TB1_COUNT_OFF)),
    .load_value (pwdata[15:0]),
    .count      (count1),
    .period_hit (hit1)
  );

  // Time base selection; one picks the second timer
  assign timer_count        = timebase_select ? count1 : count0;  // see RL9, RL23
  assign timebase_run       = timebase_select ? run1 : run0;      // see RL10
  assign period_hit         = timebase_select ? hit1 : hit0;

  // Matches count only while the time base runs, full-width equality
  wire prim_match = timebase_run && (timer_count == primary_compare_value);   // see RL25
  wire sec_match  = timebase_run && (timer_count == secondary_compare_value); // see RL25
  wire fault_hit  = (compare_mode_select == `OCP_MODE_PWM_FLT) && fault_input_pin;
  // Trailing match ends only a begun pulse, so a rearm mid-period still pulses
  wire pulse_end  = armed && sec_match && (compare_output_pin || prim_match); // see RL5

  // Output and event decision per mode
  always @* begin
    next_out      = compare_output_pin;
    next_flag_set = 1'b0;
    case (compare_mode_select)
      `OCP_MODE_OFF: begin
        next_out = 1'b0; // see RL22
      end
      `OCP_MODE_SET_HIGH: begin
        if (prim_match) begin
          next_out      = 1'b1; // see RL22
          next_flag_set = 1'b1;
        end
      end
      `OCP_MODE_SET_LOW: begin
        if (prim_match) begin
          next_out      = 1'b0; // see RL22
          next_flag_set = 1'b1;
        end
      end
      `OCP_MODE_TOGGLE: begin
        if (prim_match) begin
          next_out      = !compare_output_pin; // see RL22
          next_flag_set = 1'b1;
        end
      end
      `OCP_MODE_SINGLE: begin
        // Secondary checked last: equal values end in low
        if (armed && prim_match) begin
          next_out = 1'b1; // see RL2
        end
        if (pulse_end) begin
          next_out      = 1'b0; // see RL3
          next_flag_set = 1'b1; // see RL4
        end
      end
      `OCP_MODE_CONT: begin
        if (prim_match) begin
          next_out = 1'b1; // see RL2, RL6
        end
        if (sec_match) begin
          next_out      = 1'b0; // see RL6
          next_flag_set = 1'b1; // see RL8
        end
      end
      `OCP_MODE_PWM, `OCP_MODE_PWM_FLT: begin
        // High while count is below duty; covers 0 %, 100 % and equal cases
        next_out = (timer_count < primary_compare_value); // see RL16, RL17, RL18
        if (fault_status || fault_hit) begin
          next_out = 1'b0; // see RL24
        end
        if (fault_hit && !fault_status) begin
          next_flag_set = 1'b1; // see RL19
        end
      end
      default: begin
        next_out = 1'b0;
      end
    endcase
    // A mode write re-initialises the pin over any match; PWM codes keep its level
    if (mode_wr) begin
      case (pwdata[`OCP_MODE_MSB:`OCP_MODE_LSB])
        `OCP_MODE_SET_LOW: next_out = 1'b1;
        `OCP_MODE_PWM, `OCP_MODE_PWM_FLT: next_out = compare_output_pin;
        default: next_out = 1'b0; // see RL1, RL6
      endcase
    end
  end

  // Control and compare registers
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compare_mode_select     <= `OCP_MODE_OFF;
      timebase_select         <= 1'b0;
      fault_status            <= 1'b0;
      primary_compare_value   <= `OCP_RST16;
      secondary_compare_value <= `OCP_RST16;
      compare_irq_enable      <= 1'b0;
      run0                    <= 1'b0;
      run1                    <= 1'b0;
      period0                 <= `OCP_PERIOD_RST;
      period1                 <= `OCP_PERIOD_RST;
      armed                   <= 1'b0;
      compare_output_pin      <= 1'b0;
    end else begin
      compare_output_pin <= next_out;
      // Single pulse consumed by its trailing match
      if ((compare_mode_select == `OCP_MODE_SINGLE) && pulse_end) begin
        armed <= 1'b0; // see RL3
      end
      // Fault latches; only a mode rewrite clears it
      if (fault_hit) begin
        fault_status <= 1'b1; // see RL21
      end
      // Double buffer: next duty taken at the period boundary
      if (is_pwm(compare_mode_select) && period_hit) begin
        primary_compare_value <= secondary_compare_value; // see RL13, RL15
      end
      if (wr_en) begin
        case (paddr)
          `OCP_CONTROL_OFF: begin
            compare_mode_select <= pwdata[`OCP_MODE_MSB:`OCP_MODE_LSB];
            timebase_select     <= pwdata[`OCP_TSEL_BIT];
            armed               <= 1'b1; // see RL1, RL5
            fault_status        <= 1'b0; // see RL24
          end
          `OCP_PRIMARY_OFF: begin
            // Duty register is read-only in PWM; first duty kept as loaded
            if (!is_pwm(compare_mode_select)) begin
              primary_compare_value <= pwdata[15:0]; // see RL12, RL14
            end
          end
          `OCP_SECONDARY_OFF: secondary_compare_value <= pwdata[15:0];
          `OCP_IRQ_EN_OFF:    compare_irq_enable <= pwdata[0];
          `OCP_TB0_CTRL_OFF:  run0 <= pwdata[`OCP_RUN_BIT];
          `OCP_TB0_PERIOD_OFF: period0 <= pwdata[15:0];
          `OCP_TB1_CTRL_OFF:  run1 <= pwdata[`OCP_RUN_BIT];
          `OCP_TB1_PERIOD_OFF: period1 <= pwdata[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Sticky flag: write one to clear, a new event wins over the clear
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compare_irq_flag <= 1'b0;
      compare_irq      <= 1'b0;
    end else begin
      if (next_flag_set) begin
        compare_irq_flag <= 1'b1; // see RL4, RL8
      end else if (wr_en && (paddr == `OCP_IRQ_FLAG_OFF) && pwdata[0]) begin
        compare_irq_flag <= 1'b0;
      end
      // Request only when enabled; one cycle behind the flag
      compare_irq <= compare_irq_flag && compare_irq_enable; // see RL4
    end
  end

  // APB answer: read data and ready captured in the setup cycle
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= 32'h00000000;
      if (setup && !pwrite) begin
        case (paddr)
          `OCP_CONTROL_OFF: begin
            prdata[`OCP_MODE_MSB:`OCP_MODE_LSB] <= compare_mode_select;
            prdata[`OCP_TSEL_BIT]  <= timebase_select;
            prdata[`OCP_FAULT_BIT] <= fault_status;
          end
          `OCP_PRIMARY_OFF:    prdata[15:0] <= primary_compare_value;
          `OCP_SECONDARY_OFF:  prdata[15:0] <= secondary_compare_value;
          `OCP_IRQ_FLAG_OFF:   prdata[0] <= compare_irq_flag;
          `OCP_IRQ_EN_OFF:     prdata[0] <= compare_irq_enable;
          `OCP_TB0_CTRL_OFF:   prdata[`OCP_RUN_BIT] <= run0;
          `OCP_TB0_PERIOD_OFF: prdata[15:0] <= period0;
          `OCP_TB0_COUNT_OFF:  prdata[15:0] <= count0;
          `OCP_TB1_CTRL_OFF:   prdata[`OCP_RUN_BIT] <= run1;
          `OCP_TB1_PERIOD_OFF: prdata[15:0] <= period1;
          `OCP_TB1_COUNT_OFF:  prdata[15:0] <= count1;
          default: begin
          end
        endcase
      end
    end
  end
  // Period below secondary is not trapped: software keeps the order, see RL11
  // A secondary beyond the period never matches, so a pulse would stay high
endmodule
`default_nettype wire

// File: ocp_timebase.v
// One 16-bit timer time base: counts while running, wraps at period.
// Assumes software loads count and period through the parent's bus.
`timescale 1ns/10ps
`default_nettype none
`include "ocp_map.vh"
module ocp_timebase (
  input  wire        ref_clk,    // Core clock
  input  wire        sys_rst,    // Async reset, high
  input  wire        run,        // Count enable
  input  wire [15:0] period,     // Period value
  input  wire        load,       // Software count write
  input  wire [15:0] load_value, // Value to load
  output reg  [15:0] count,      // Current count
  output wire        period_hit  // Count equals period while running
);
  // Match qualified by run so a stopped timer raises no events
  assign period_hit = run && (count == period);

  // Counter: load beats counting, wrap to zero at period
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= `OCP_RST16;
    end else if (load) begin
      count <= load_value;
    end else if (period_hit) begin
      count <= `OCP_RST16; // see RL7
    end else if (run) begin
      count <= count + 16'h0001; // see RL10
    end
  end
endmodule
`default_nettype wire

// File: output_compare_pwm_channel_tb.sv
// Self-checking bench for the compare channel, driven over APB.
// Assumes the checker binds itself and ocp_load watches the pin.
`timescale 1ns/10ps
`default_nettype none
module output_compare_pwm_channel_tb;
  logic        ref_clk = 1'b0;         // 10 MHz clock
  logic        sys_rst = 1'b1;         // Reset, high
  logic        psel = 1'b0;            // APB select
  logic        penable = 1'b0;         // APB enable
  logic        pwrite = 1'b0;          // APB direction
  logic [7:0]  paddr = 8'h00;          // APB address
  logic [31:0] pwdata = 32'h0;         // APB write data
  logic        fault_input_pin = 1'b0; // Fault drive
  logic        ld_clr = 1'b0;          // Load restart
  logic        last_err = 1'b0;        // Error seen on last transfer
  wire  [31:0] prdata;                 // Read data
  wire         pready;                 // Ready
  wire         pslverr;                // Error
  wire         compare_output_pin;     // Pin
  wire         compare_irq;            // Irq
  wire  [7:0]  rises;                  // Load rising edges
  wire  [7:0]  highs;                  // Load high cycles
  int          miscompares = 0;        // Failed checks
  int          checks = 0;             // All checks
  ocp_output_compare dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fault_input_pin, .compare_output_pin, .compare_irq);
  ocp_load load (.ref_clk, .sys_rst, .clr(ld_clr), .pin(compare_output_pin), .rises, .highs);
  // Clock, 100 ns period
  always #50 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic clr_ld;
    ld_clr <= 1'b1;
    @(posedge ref_clk);
    ld_clr <= 1'b0;
  endtask
  // Let n edges pass, then judge what the load saw
  task automatic obs(input int n, input logic [7:0] er, input logic [7:0] eh);
    repeat (n) @(posedge ref_clk);
    #1;
    chk("rises", 32'(rises), 32'(er));
    chk("highs", 32'(highs), 32'(eh));
    // Back on the edge so the caller's next drive lands on it
    @(posedge ref_clk);
  endtask
  task automatic meas(input int n, input logic [7:0] er, input logic [7:0] eh);
    clr_ld;
    obs(n, er, eh);
  endtask
  task automatic t_reset;
    rdchk(8'h00, 32'h0, "control");
    rdchk(8'h18, 32'hFFFF, "period0");
    chk("mapped err", 32'(last_err), 32'h0);
    rdchk(8'h40, 32'h0, "unmapped");
    chk("unmapped err", 32'(last_err), 32'h1);
    $display("reset done");
  endtask
  task automatic t_single;
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h4);
    wr(8'h24, 32'h5);
    wr(8'h10, 32'h1);
    clr_ld;
    wr(8'h00, 32'h4);
    obs(20, 0, 0);
    clr_ld;
    wr(8'h00, 32'hC);
    wr(8'h20, 32'h8000);
    obs(30, 1, 2);
    rdchk(8'h0C, 32'h1, "flag");
    chk("irq", 32'(compare_irq), 32'h1);
    wr(8'h0C, 32'h1);
    clr_ld;
    wr(8'h00, 32'hC);
    obs(20, 1, 2);
    $display("single done");
  endtask
  task automatic t_cont;
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h3);
    wr(8'h00, 32'hD);
    repeat (6) @(posedge ref_clk);
    meas(24, 4, 8);
    wr(8'h0C, 32'h1);
    repeat (8) @(posedge ref_clk);
    rdchk(8'h0C, 32'h1, "flag again");
    $display("cont done");
  endtask
  // Duty changes only land at the period match, hence the waits
  task automatic t_pwm;
    wr(8'h00, 32'h8);
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h3);
    wr(8'h24, 32'h7);
    wr(8'h00, 32'hE);
    wr(8'h04, 32'h9);
    rdchk(8'h04, 32'h3, "primary");
    meas(32, 4, 12);
    wr(8'h08, 32'h0);
    repeat (10) @(posedge ref_clk);
    meas(16, 0, 0);
    wr(8'h08, 32'h9);
    repeat (10) @(posedge ref_clk);
    meas(16, 0, 16);
    rdchk(8'h04, 32'h9, "duty");
    wr(8'h08, 32'h7);
    repeat (10) @(posedge ref_clk);
    meas(16, 2, 14);
    $display("pwm done");
  endtask
  // Irq enable stays set from earlier, as fault use needs it
  task automatic t_fault;
    rdchk(8'h10, 32'h1, "irq enable");
    wr(8'h08, 32'h9);
    wr(8'h00, 32'hF);
    repeat (10) @(posedge ref_clk);
    fault_input_pin <= 1'b1;
    @(posedge ref_clk);
    fault_input_pin <= 1'b0;
    meas(16, 0, 0);
    rdchk(8'h00, 32'h1F, "fault set");
    wr(8'h00, 32'hE);
    fault_input_pin <= 1'b1;
    repeat (10) @(posedge ref_clk);
    meas(16, 0, 16);
    fault_input_pin <= 1'b0;
    wr(8'h00, 32'hF);
    rdchk(8'h00, 32'hF, "fault clear");
    $display("fault done");
  endtask
  // Count reloaded each pass so exactly one match lands in the wait
  task automatic t_codes;
    logic [3:0] pin_exp;
    pin_exp = 4'b1010;
    wr(8'h00, 32'h8);
    wr(8'h04, 32'h2);
    for (int m = 0; m < 4; m++) begin
      wr(8'h28, 32'h4);
      wr(8'h00, 32'h8 | m);
      repeat (5) @(posedge ref_clk);
      #1;
      chk("mode pin", 32'(compare_output_pin), 32'(pin_exp[m]));
    end
    $display("codes done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_single;
    t_cont;
    t_pwm;
    t_fault;
    t_codes;
    tally_and_finish;
  end
  // Watchdog, well above the roughly 460 cycles the tests need
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
